// ===== rpm_pkg.sv
// constants, register map and types of the reset and power mode controller
package rpm_pkg;

  // ----------------------------------------------------------------
  // reset stretch timing
  // ----------------------------------------------------------------
  localparam int unsigned STRETCH_CYCLES = 257;
  localparam int CNT_W = 9;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] GATE_ONE_IDX = 8'hDB;
  localparam logic [7:0] GATE_TWO_IDX = 8'hDC;
  localparam logic [7:0] CAUSE_IDX = 8'hDD;
  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------
  // reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] GATE_ONE_RST = 8'h00;
  localparam logic [7:0] GATE_TWO_RST = 8'h00;
  localparam logic [7:0] GATE_ONE_WMASK = 8'hEF;
  localparam logic [7:0] GATE_TWO_WMASK = 8'hBF;
  localparam logic [5:0] CAUSE_RST = 6'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int G1_PORT_B = 5;
  localparam int G1_SPI = 3;
  localparam int G2_CLK_OUT = 7;
  localparam int N_TIMERS = 6;
  localparam int N_PERIPH = 13;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_BOR = 1;
  localparam int CAUSE_EXT = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_RTC = 4;
  localparam int CAUSE_DBG = 5;
  localparam int N_CAUSE = 6;

  // ----------------------------------------------------------------
  // parked bus values
  // ----------------------------------------------------------------
  localparam int N_CTRL = 10;
  localparam logic [9:0] CTRL_IDLE = 10'h3FF;
  localparam logic [7:0] DATA_PARK = 8'h00;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_HALT} rpm_pwr_e;

endpackage

// ===== rpm_stretch_if.sv
// link between the controller and its reset stretch counter
`timescale 1ns/10ps
interface rpm_stretch_if;
  logic req;
  logic hold;
  logic [rpm_pkg::CNT_W-1:0] cnt;
  modport ctl (input req, output hold, output cnt);
  modport user (output req, input hold, input cnt);
endinterface

// ===== rpm_stretch.sv
// reset stretch counter holding reset for a fixed number of cycles
`timescale 1ns/10ps
module rpm_stretch
(
  input wire logic clk,
  input wire logic sys_rst,
  rpm_stretch_if.ctl sif
);

  logic hold_reg;
  logic hold_next;
  logic [rpm_pkg::CNT_W-1:0] cnt_reg;
  logic [rpm_pkg::CNT_W-1:0] cnt_next;
  localparam logic [rpm_pkg::CNT_W-1:0] LAST =
    rpm_pkg::CNT_W'(rpm_pkg::STRETCH_CYCLES - 1);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb
  begin
    hold_next = hold_reg;
    cnt_next = cnt_reg;
    if (sif.req)
    begin
      // any request restarts the full count
      hold_next = 1'b1;
      cnt_next = '0;
    end
    else if (hold_reg)
    begin
      // counting starts at the first edge with no request
      if (cnt_reg == LAST)
        hold_next = 1'b0;
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hold_reg <= 1'b1;
      cnt_reg <= '0;
    end
    else
    begin
      hold_reg <= hold_next;
      cnt_reg <= cnt_next;
    end
  end

  assign sif.hold = hold_reg;
  assign sif.cnt = cnt_reg;

endmodule // rpm_stretch

// ===== rpm_ctrl.sv
// reset and power mode controller with clock gate registers on avalon-mm
//
// Notes on behaviour
// - six sources merge into one system reset
// - reset defaults registers, inputs ports, clears pc
// - reset held 257 cycles after requests
// - counting starts first edge after requests end
// - power-on reset waits for counter completion
// - sleep stops oscillator, clock and cpu
// - sleep exits only by pin, alarm, debug, por or brownout
// - sleep exit takes the full stretch delay
// - sleep parks data low, strobes high, address held
// - halt idles cpu, clocks keep running
// - halt exits on interrupts, watchdog or reset
// - halt parks bus like sleep
// - gates clear at reset; 1 stops clock
// - gated peripheral registers refuse cpu access
// - first register gates ports, spi, i2c, uarts
// - gated port loses its alternate functions
// - second register bit7 disables clock output
// - second register low bits gate six timers
`timescale 1ns/10ps
module rpm_ctrl
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [rpm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic por_request,
  input wire logic brownout_reset_request,
  input wire logic ext_reset_n,
  input wire logic watchdog_timer_timeout,
  input wire logic watchdog_timer_reset_mode,
  input wire logic rtc_alarm,
  input wire logic debug_reset_cmd,
  input wire logic sleep_instruction,
  input wire logic halt_instruction,
  input wire logic nmi_request,
  input wire logic irq_request,
  input wire logic [23:0] cpu_address,
  input wire logic [7:0] cpu_data_out,
  input wire logic [rpm_pkg::N_CTRL-1:0] cpu_bus_ctrl_n,
  output logic system_reset,
  output logic pc_clear,
  output logic gpio_force_input,
  output logic cpu_run_en,
  output logic primary_osc_en,
  output logic system_clock_en,
  output logic in_sleep,
  output logic in_halt,
  output logic [23:0] bus_address,
  output logic [7:0] bus_data_out,
  output logic [rpm_pkg::N_CTRL-1:0] bus_ctrl_n,
  output logic [rpm_pkg::N_PERIPH-1:0] periph_clk_en,
  output logic [rpm_pkg::N_PERIPH-1:0] periph_reg_access_en,
  output logic [2:0] port_alt_en,
  output logic system_clock_output_pin_oe
);

  // ----------------------------------------------------------------
  // synchronisers for inputs from outside the clock domain
  // ----------------------------------------------------------------
  // por, brownout and rtc come from analog or 32 kHz logic, the pin from outside
  // the pin is synchronised raw, so its stage idles high and inverts after the second flop
  logic [3:0] async_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;

  assign async_in = {rtc_alarm, ext_reset_n, brownout_reset_request, por_request};

  always_comb
  begin
    sync1_next = async_in;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 4'h4;
      sync2_reg <= 4'h4;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ----------------------------------------------------------------
  // reset request merge and stretch
  // ----------------------------------------------------------------
  rpm_pkg::rpm_pwr_e pwr_reg;
  rpm_pkg::rpm_pwr_e pwr_next;
  logic [rpm_pkg::N_CAUSE-1:0] req_vec;
  logic hold;
  rpm_stretch_if sif ();

  always_comb
  begin
    req_vec = '0;
    req_vec[rpm_pkg::CAUSE_POR] = sync2_reg[0];
    req_vec[rpm_pkg::CAUSE_BOR] = sync2_reg[1];
    req_vec[rpm_pkg::CAUSE_EXT] = ~sync2_reg[2];
    // a watchdog reset cannot wake sleep
    req_vec[rpm_pkg::CAUSE_WDT] = watchdog_timer_timeout & watchdog_timer_reset_mode
      & (pwr_reg != rpm_pkg::PWR_SLEEP);
    // the alarm only resets while sleeping
    req_vec[rpm_pkg::CAUSE_RTC] = sync2_reg[3] & (pwr_reg == rpm_pkg::PWR_SLEEP);
    req_vec[rpm_pkg::CAUSE_DBG] = debug_reset_cmd;
  end

  assign sif.req = |req_vec;
  assign hold = sif.hold;

  rpm_stretch u_stretch
  (
    .clk (clk),
    .sys_rst (sys_rst),
    .sif (sif)
  );

  // ----------------------------------------------------------------
  // reset cause capture
  // ----------------------------------------------------------------
  // a new episode starts when a request appears outside the hold window
  logic [rpm_pkg::N_CAUSE-1:0] cause_reg;
  logic [rpm_pkg::N_CAUSE-1:0] cause_next;

  always_comb
  begin
    cause_next = cause_reg;
    if (sif.req && !hold)
      cause_next = req_vec;
    else if (sif.req)
      cause_next = cause_reg | req_vec;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cause_reg <= rpm_pkg::CAUSE_RST;
    else
      cause_reg <= cause_next;
  end

  // ----------------------------------------------------------------
  // power mode state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    pwr_next = pwr_reg;
    if (sif.req || hold)
      // every reset, including a sleep wake, runs the full stretch
      pwr_next = rpm_pkg::PWR_RUN;
    else
    begin
      unique case (pwr_reg)
        rpm_pkg::PWR_RUN:
        begin
          if (sleep_instruction)
            pwr_next = rpm_pkg::PWR_SLEEP;
          else if (halt_instruction)
            pwr_next = rpm_pkg::PWR_HALT;
        end
        rpm_pkg::PWR_SLEEP:
          // left only through a reset request
          pwr_next = rpm_pkg::PWR_SLEEP;
        rpm_pkg::PWR_HALT:
        begin
          if (nmi_request || irq_request || watchdog_timer_timeout)
            pwr_next = rpm_pkg::PWR_RUN;
        end
        default:
          pwr_next = rpm_pkg::PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pwr_reg <= rpm_pkg::PWR_RUN;
    else
      pwr_reg <= pwr_next;
  end

  // ----------------------------------------------------------------
  // cpu, clock and bus control outputs
  // ----------------------------------------------------------------
  logic park;
  logic run_next;
  logic osc_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [rpm_pkg::N_CTRL-1:0] ctrl_reg;
  logic [rpm_pkg::N_CTRL-1:0] ctrl_next;
  logic run_reg;
  logic osc_reg;
  logic sleep_reg;
  logic halt_reg;

  always_comb
  begin
    // parking is computed from the next state so the bus is quiet on entry
    park = (pwr_next != rpm_pkg::PWR_RUN) || sif.req || hold;
    run_next = (pwr_next == rpm_pkg::PWR_RUN) && !sif.req && !hold;
    osc_next = (pwr_next != rpm_pkg::PWR_SLEEP);
    addr_next = park ? addr_reg : cpu_address;
    data_next = park ? rpm_pkg::DATA_PARK : cpu_data_out;
    ctrl_next = park ? rpm_pkg::CTRL_IDLE : cpu_bus_ctrl_n;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      run_reg <= 1'b0;
      osc_reg <= 1'b1;
      sleep_reg <= 1'b0;
      halt_reg <= 1'b0;
      addr_reg <= 24'h000000;
      data_reg <= rpm_pkg::DATA_PARK;
      ctrl_reg <= rpm_pkg::CTRL_IDLE;
    end
    else
    begin
      run_reg <= run_next;
      osc_reg <= osc_next;
      sleep_reg <= (pwr_next == rpm_pkg::PWR_SLEEP);
      halt_reg <= (pwr_next == rpm_pkg::PWR_HALT);
      addr_reg <= addr_next;
      data_reg <= data_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave and clock gate registers
  // ----------------------------------------------------------------
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] gate1_reg;
  logic [7:0] gate1_next;
  logic [7:0] gate2_reg;
  logic [7:0] gate2_next;
  logic word_ok;
  logic wr_take;
  logic [7:0] wbyte;

  always_comb
  begin
    word_ok = (avs_address[1:0] == 2'b00);
    // one wait cycle, then the request is taken with waitrequest low
    wait_next = !((avs_read || avs_write) && wait_reg);
    wr_take = avs_write && !wait_reg && avs_byteenable[0] && word_ok;
    wbyte = avs_writedata[7:0];
    rdata_next = rdata_reg;
    if (avs_read && wait_reg)
    begin
      rdata_next = 32'h00000000;
      if (word_ok && avs_address[9:2] == rpm_pkg::GATE_ONE_IDX)
        rdata_next[7:0] = gate1_reg & rpm_pkg::GATE_ONE_WMASK;
      else if (word_ok && avs_address[9:2] == rpm_pkg::GATE_TWO_IDX)
        rdata_next[7:0] = gate2_reg & rpm_pkg::GATE_TWO_WMASK;
      else if (word_ok && avs_address[9:2] == rpm_pkg::CAUSE_IDX)
        rdata_next[rpm_pkg::N_CAUSE-1:0] = cause_reg;
    end
    gate1_next = gate1_reg;
    gate2_next = gate2_reg;
    if (wr_take && avs_address[9:2] == rpm_pkg::GATE_ONE_IDX)
      gate1_next = wbyte & rpm_pkg::GATE_ONE_WMASK;
    if (wr_take && avs_address[9:2] == rpm_pkg::GATE_TWO_IDX)
      gate2_next = wbyte & rpm_pkg::GATE_TWO_WMASK;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // the stretched system reset also returns the gates to all-enabled
  always_ff @(posedge clk)
  begin
    if (sys_rst || hold)
    begin
      gate1_reg <= rpm_pkg::GATE_ONE_RST;
      gate2_reg <= rpm_pkg::GATE_TWO_RST;
    end
    else
    begin
      gate1_reg <= gate1_next;
      gate2_reg <= gate2_next;
    end
  end

  // ----------------------------------------------------------------
  // peripheral clock gating
  // ----------------------------------------------------------------
  // order: uart1, uart2, i2c, spi, port b, c, d, timers 0 to 5
  logic [rpm_pkg::N_PERIPH-1:0] pclk_next;
  logic [rpm_pkg::N_PERIPH-1:0] pacc_next;
  logic [rpm_pkg::N_PERIPH-1:0] pclk_reg;
  logic [rpm_pkg::N_PERIPH-1:0] pacc_reg;
  logic [2:0] alt_reg;
  logic [2:0] alt_next;
  logic clk_oe_reg;
  logic clk_oe_next;

  always_comb
  begin
    pclk_next = ~{gate2_next[rpm_pkg::N_TIMERS-1:0],
      gate1_next[7:rpm_pkg::G1_PORT_B], gate1_next[rpm_pkg::G1_SPI:0]};
    // registers of a stopped peripheral, or any during reset, are not reachable
    pacc_next = hold ? '0 : pclk_next;
    alt_next = ~gate1_next[7:rpm_pkg::G1_PORT_B];
    // the pin floats when disabled; the driving clock itself is outside
    clk_oe_next = ~gate2_next[rpm_pkg::G2_CLK_OUT];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pclk_reg <= '1;
      pacc_reg <= '0;
      alt_reg <= 3'h7;
      clk_oe_reg <= 1'b1;
    end
    else
    begin
      pclk_reg <= pclk_next;
      pacc_reg <= pacc_next;
      alt_reg <= alt_next;
      clk_oe_reg <= clk_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // output assignments
  // ----------------------------------------------------------------
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign system_reset = hold;
  assign pc_clear = hold;
  assign gpio_force_input = hold;
  assign cpu_run_en = run_reg;
  assign primary_osc_en = osc_reg;
  assign system_clock_en = osc_reg;
  assign in_sleep = sleep_reg;
  assign in_halt = halt_reg;
  assign bus_address = addr_reg;
  assign bus_data_out = data_reg;
  assign bus_ctrl_n = ctrl_reg;
  assign periph_clk_en = pclk_reg;
  assign periph_reg_access_en = pacc_reg;
  assign port_alt_en = alt_reg;
  assign system_clock_output_pin_oe = clk_oe_reg;

endmodule // rpm_ctrl

// ===== rpm_ctrl_properties.sv
// concurrent checks on the ports of the reset and power mode controller
`timescale 1ns/10ps
module rpm_props
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [rpm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic debug_reset_cmd,
  input wire logic irq_request,
  input wire logic system_reset,
  input wire logic pc_clear,
  input wire logic gpio_force_input,
  input wire logic cpu_run_en,
  input wire logic primary_osc_en,
  input wire logic system_clock_en,
  input wire logic in_sleep,
  input wire logic in_halt,
  input wire logic [23:0] bus_address,
  input wire logic [7:0] bus_data_out,
  input wire logic [rpm_pkg::N_CTRL-1:0] bus_ctrl_n,
  input wire logic [rpm_pkg::N_PERIPH-1:0] periph_clk_en,
  input wire logic [rpm_pkg::N_PERIPH-1:0] periph_reg_access_en,
  input wire logic [2:0] port_alt_en,
  input wire logic system_clock_output_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // saturating count of cycles spent in reset; only a lower bound is checked
  logic [9:0] hi_cnt_reg, hi_cnt_next;
  logic wr_acc;
  assign wr_acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_comb
  begin
    hi_cnt_next = hi_cnt_reg;
    if (sys_rst || !system_reset)
      hi_cnt_next = 10'h000;
    else if (hi_cnt_reg != 10'h3FF)
      hi_cnt_next = hi_cnt_reg + 10'h001;
  end
  always_ff @(posedge clk)
    hi_cnt_reg <= hi_cnt_next;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_dbg_request: assert property (debug_reset_cmd |=> system_reset)
    else $error("debug command did not raise system reset");
  a_reset_state: assert property (system_reset |-> pc_clear && gpio_force_input && !cpu_run_en)
    else $error("reset state outputs wrong");
  a_stretch_min: assert property ($fell(system_reset) |-> hi_cnt_reg >= 10'h101)
    else $error("reset released before full stretch");
  a_run_resume: assert property ($fell(system_reset) |=> cpu_run_en)
    else $error("execution did not resume after reset");
  a_sleep_clocks: assert property (in_sleep |-> !primary_osc_en && !system_clock_en && !cpu_run_en)
    else $error("clocks or cpu active in sleep");
  a_halt_clocks: assert property (in_halt |-> primary_osc_en && system_clock_en && !cpu_run_en)
    else $error("halt clocks or cpu wrong");
  a_park_bus: assert property (in_sleep || in_halt |-> bus_data_out == 8'h00 && bus_ctrl_n == 10'h3FF)
    else $error("bus not parked in low power state");
  a_hold_addr: assert property ((in_sleep || in_halt) && ($past(in_sleep) || $past(in_halt))
    |-> $stable(bus_address)) else $error("address moved in low power state");
  a_halt_wake: assert property (in_halt && irq_request && !system_reset |=> !in_halt)
    else $error("interrupt did not end halt");
  a_gate_one: assert property (wr_acc && avs_address == 10'h36C && !system_reset
    |=> periph_clk_en[6:0] == ~{$past(avs_writedata[7:5]), $past(avs_writedata[3:0])})
    else $error("first gate write not applied");
  a_gate_two: assert property (wr_acc && avs_address == 10'h370 && !system_reset
    |=> periph_clk_en[12:7] == ~$past(avs_writedata[5:0])
    && system_clock_output_pin_oe == !$past(avs_writedata[7]))
    else $error("second gate write not applied");
  // the access mask is registered from the reset level one edge earlier
  a_access_gated: assert property (periph_reg_access_en ==
    (periph_clk_en & {rpm_pkg::N_PERIPH{!$past(system_reset)}})) else $error("access enable wrong");
  a_port_alt: assert property (port_alt_en == periph_clk_en[6:4])
    else $error("alternate function enable wrong");
endmodule // rpm_props

// ===== rpm_cpu_model.sv
// behavioural cpu core driving the bus pins that the controller parks
`timescale 1ns/10ps
module rpm_cpu_model
(
  input wire logic clk,
  input wire logic pc_clear,
  input wire logic cpu_run_en,
  output logic [23:0] cpu_address,
  output logic [7:0] cpu_data_out,
  output logic [rpm_pkg::N_CTRL-1:0] cpu_bus_ctrl_n
);
  // an idle core stops driving, so its pins toggle and only parking hides them
  always_ff @(posedge clk)
  begin
    if (pc_clear)
    begin
      cpu_address <= 24'h000000;
      cpu_data_out <= 8'h00;
      cpu_bus_ctrl_n <= 10'h3FF;
    end
    else if (cpu_run_en)
    begin
      cpu_address <= cpu_address + 24'h000001;
      cpu_data_out <= cpu_address[7:0];
      cpu_bus_ctrl_n <= {cpu_address[4:0], ~cpu_address[4:0]};
    end
    else
    begin
      cpu_address <= ~cpu_address;
      cpu_data_out <= ~cpu_data_out;
      cpu_bus_ctrl_n <= ~cpu_bus_ctrl_n;
    end
  end
endmodule // rpm_cpu_model

// ===== rpm_ctrl_tb.sv
// self-checking testbench of the reset and power mode controller
`timescale 1ns/10ps
module rpm_ctrl_tb;
  logic clk = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  logic [9:0] avs_address = 10'h000, a;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic por_request = 1'h0, brownout_reset_request = 1'h0, ext_reset_n = 1'h1;
  logic watchdog_timer_timeout = 1'h0, watchdog_timer_reset_mode = 1'h0, rtc_alarm = 1'h0;
  logic debug_reset_cmd = 1'h0, sleep_instruction = 1'h0, halt_instruction = 1'h0;
  logic nmi_request = 1'h0, irq_request = 1'h0;
  logic avs_waitrequest, system_reset, pc_clear, gpio_force_input, cpu_run_en;
  logic primary_osc_en, system_clock_en, in_sleep, in_halt, system_clock_output_pin_oe;
  logic [23:0] cpu_address, bus_address, hold_a;
  logic [7:0] cpu_data_out, bus_data_out, g1, g2, v;
  logic [9:0] cpu_bus_ctrl_n, bus_ctrl_n;
  logic [12:0] periph_clk_en, periph_reg_access_en, e;
  logic [2:0] port_alt_en;
  int errors = 0, total_checks = 0, n;
  int sk[3] = '{2, 4, 5};
  int hk[3] = '{8, 9, 3};

  rpm_ctrl i_rpm_ctrl (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .por_request, .brownout_reset_request,
    .ext_reset_n, .watchdog_timer_timeout, .watchdog_timer_reset_mode, .rtc_alarm,
    .debug_reset_cmd, .sleep_instruction, .halt_instruction, .nmi_request, .irq_request,
    .cpu_address, .cpu_data_out, .cpu_bus_ctrl_n, .system_reset, .pc_clear, .gpio_force_input,
    .cpu_run_en, .primary_osc_en, .system_clock_en, .in_sleep, .in_halt, .bus_address,
    .bus_data_out, .bus_ctrl_n, .periph_clk_en, .periph_reg_access_en, .port_alt_en,
    .system_clock_output_pin_oe);
  rpm_cpu_model i_rpm_cpu_model (.clk, .pc_clear, .cpu_run_en, .cpu_address, .cpu_data_out,
    .cpu_bus_ctrl_n);

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    total_checks++;
    if (got !== ex)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask

  // one avalon transfer; the request stands until waitrequest is seen low
  task automatic av(logic w, logic [9:0] ad, logic [7:0] d, logic [3:0] be);
    int c;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end while (avs_waitrequest !== 1'h0 && c < 50);
    if (c >= 50)
      errors++;
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task automatic rd_chk(string nm, logic [9:0] ad, logic [31:0] ex);
    av(1'h0, ad, 8'h00, 4'hF);
    chk(nm, ex, q);
  endtask

  task automatic set_src(int k, logic s);
    @(posedge clk);
    case (k)
      0: por_request <= s;
      1: brownout_reset_request <= s;
      2: ext_reset_n <= !s;
      3: watchdog_timer_timeout <= s;
      4: rtc_alarm <= s;
      5: debug_reset_cmd <= s;
      6: sleep_instruction <= s;
      7: halt_instruction <= s;
      8: irq_request <= s;
      default: nmi_request <= s;
    endcase
  endtask

  task automatic pulse(int k);
    set_src(k, 1'h1);
    set_src(k, 1'h0);
  endtask

  task automatic stretch(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
      #1;
    end while (system_reset !== 1'h0 && c < 400);
  endtask

  // one reset episode from source k, stretch measured from the request's drop
  task automatic ep(int k, int lo, int hi);
    set_src(k, 1'h1);
    tick(4);
    #1 chk("system_reset", 1, system_reset);
    set_src(k, 1'h0);
    stretch(n);
    chk("stretch", 1, n >= lo && n <= hi);
    @(posedge clk);
    #1 chk("cpu_run_en", 1, cpu_run_en);
    rd_chk("cause", 10'h374, 32'h00000001 << k);
  endtask

  function automatic logic [12:0] en_of(logic [7:0] r1, logic [7:0] r2);
    return ~{r2[5:0], r1[7:5], r1[3:0]};
  endfunction

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    stretch(n);
    chk("stretch", 257, n);
    chk("clk_en", 14'h3FFF, {system_clock_output_pin_oe, periph_clk_en});
    rd_chk("gate_one", 10'h36C, 32'h00000000);
    rd_chk("gate_two", 10'h370, 32'h00000000);
    g1 = 8'h00;
    g2 = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      v = 8'h01 << (i % 8);
      a = (i < 8) ? 10'h36C : 10'h370;
      if (i < 8)
        g1 = v & 8'hEF;
      else
        g2 = v & 8'hBF;
      av(1'h1, a, v, 4'hF);
      #1 e = en_of(g1, g2);
      chk("clk_en", e, periph_clk_en);
      chk("access_en", e, periph_reg_access_en);
      chk("alt_en", e[6:4], port_alt_en);
      chk("clk_oe", !g2[7], system_clock_output_pin_oe);
      rd_chk("gate", a, (i < 8) ? g1 : g2);
    end
    av(1'h1, 10'h36C, 8'hFF, 4'hE);
    av(1'h1, 10'h36D, 8'hFF, 4'hF);
    av(1'h1, 10'h3FC, 8'hFF, 4'hF);
    rd_chk("gate_one", 10'h36C, {24'h000000, g1});
    rd_chk("unmapped", 10'h3FC, 32'h00000000);
    pulse(5);
    tick(100);
    ep(5, 257, 257);
    rd_chk("gate_one", 10'h36C, 32'h00000000);
    rd_chk("gate_two", 10'h370, 32'h00000000);
    watchdog_timer_reset_mode <= 1'h1;
    for (int k = 0; k < 4; k++)
      ep(k, 257, 262);
    set_src(4, 1'h1);
    tick(5);
    #1 chk("system_reset", 0, system_reset);
    set_src(4, 1'h0);
    foreach (sk[j])
    begin
      pulse(6);
      #1 chk("sleep", 3'h4, {in_sleep, primary_osc_en, system_clock_en});
      chk("park", 18'h003FF, {bus_data_out, bus_ctrl_n});
      pulse(8);
      pulse(3);
      tick(4);
      #1 chk("stay", 2'h2, {in_sleep, system_reset});
      ep(sk[j], 250, 262);
    end
    watchdog_timer_reset_mode <= 1'h0;
    av(1'h1, 10'h36C, 8'hEF, 4'hF);
    foreach (hk[j])
    begin
      pulse(7);
      #1 hold_a = bus_address;
      chk("halt", 3'h5, {in_halt, cpu_run_en, system_clock_en});
      chk("park", 18'h003FF, {bus_data_out, bus_ctrl_n});
      tick(3);
      #1 chk("hold_addr", hold_a, bus_address);
      pulse(hk[j]);
      #1 chk("wake", 2'h1, {in_halt, cpu_run_en});
    end
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule // rpm_ctrl_tb

bind rpm_ctrl rpm_props i_rpm_props (.clk, .sys_rst, .avs_address, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .debug_reset_cmd, .irq_request, .system_reset, .pc_clear,
  .gpio_force_input, .cpu_run_en, .primary_osc_en, .system_clock_en, .in_sleep, .in_halt,
  .bus_address, .bus_data_out, .bus_ctrl_n, .periph_clk_en, .periph_reg_access_en,
  .port_alt_en, .system_clock_output_pin_oe);
